// ==== core/dmc_startup_ctrl.sv ====
/*
  Speed-mode, format, mute-polarity and start-up sequencing for a stereo
  converter. Strap pins and mute pins are asynchronous and resynchronised;
  control bits arrive on plain ports from a control-port block on clk.
*/
// Function
// - Single speed accepts up to 50 kHz, oversamples 128x.
// - Double speed accepts up to 100 kHz, oversamples 64x.
// - Quad speed accepts up to 200 kHz, oversamples 32x.
// - Works at any phase between master clock and frame clock.
// - Single speed ratios 256/384/512; 768/1024/1152 need divider.
// - Double speed ratios 128..384; 512 needs divider.
// - Divided ratios only in register-configured mode.
// - Pin mode format straps decode to four fixed formats.
// - Pin mode speed straps decode speed and 44.1 kHz de-emphasis.
// - Pin mode forces auto-mute, auto polarity, fast filter.
// - Pin mode ramps volume from mute in eighth-dB per frame.
// - Pin mode disables divider, slow filter, volume and extra features.
// - Reset returns all control settings to defaults.
// - After reset wait about 2^18 clocks, then start pin mode.
// - Port enable before timeout halts pin start and reloads defaults.
// - Power-down held loads settings; clearing it starts power-up.
// - Missing port enable starts pin mode from current straps.
// - Register mode takes speed and format from register fields.
// - Mute polarity override replaces detected polarity.
// - Filter select bit picks fast or slow filter in any speed.
// - Mute pin levels sampled at reset release set mute polarity.
module dmc_startup_ctrl
  import dmc_pkg::*;
#(
  parameter int STARTUP = dmc_pkg::STARTUP_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             frameClock,
  input  wire logic [3:0]       strapPins,
  input  wire logic [1:0]       muteSense,
  input  wire logic             portEnableBit,
  input  wire logic             powerDownBit,
  input  wire logic [1:0]       speedModeField,
  input  wire logic [2:0]       formatField,
  input  wire logic [1:0]       deemphField,
  input  wire logic [1:0]       mutePolarityOverride,
  input  wire logic             filterSelect,
  input  wire logic             masterClockDivideByTwo,
  input  wire logic             masterClockDivideByThree,
  input  wire logic [dmc_pkg::VOL_W-1:0] volumeField,
  input  wire logic             zeroData,
  output logic                  registerMode,
  output logic                  running,
  output logic                  regDefaultsLoad,
  output logic      [1:0]       speedMode,
  output logic      [7:0]       oversampleRatio,
  output logic      [2:0]       audioFormat,
  output logic      [1:0]       deemphasis,
  output logic                  slowFilter,
  output logic                  masterClockDivider,
  output logic      [dmc_pkg::VOL_W-1:0] attenuation,
  output logic      [dmc_pkg::RATIO_W-1:0] clockRatio,
  output logic                  ratioValid,
  output logic      [1:0]       muteControlOutput,
  output logic      [1:0]       muteControlOe
);
  import dmc_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic       frameLast;
  wire        frameSync = syncB[0];
  wire  [3:0] strapSync = syncB[4:1];
  wire  [1:0] muteSync  = syncB[6:5];
  wire        frameEdge = frameSync & ~frameLast;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA     <= '0;
      syncB     <= '0;
      frameLast <= 1'b0;
    end else begin
      syncA     <= {muteSense, strapPins, frameClock};
      syncB     <= syncA;
      frameLast <= frameSync;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_WAIT,
    ST_PIN_RUN,
    ST_REG_HOLD,
    ST_REG_RUN
  } dmc_state_t;

  dmc_state_t state;
  dmc_state_t next_state;
  logic [1:0]  settleCount;
  logic        settleDone;
  logic [18:0] waitCount;
  logic        waitDone;
  logic [1:0]  polarity;

  // Mute pin levels reach syncB only two edges after release
  assign settleDone = (settleCount == SETTLE_LAST);
  assign waitDone = (waitCount == 19'(STARTUP - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      // Wait until the mute pin levels have crossed the synchroniser
      ST_SETTLE: begin
        if (settleDone) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (portEnableBit) begin
          next_state = ST_REG_HOLD;
        end else if (waitDone) begin
          next_state = ST_PIN_RUN;
        end
      end
      ST_PIN_RUN: begin
        // Late enable still works, but may click
        if (portEnableBit) begin
          next_state = ST_REG_HOLD;
        end
      end
      ST_REG_HOLD: begin
        if (!powerDownBit) begin
          next_state = ST_REG_RUN;
        end
      end
      ST_REG_RUN: begin
        if (powerDownBit) begin
          next_state = ST_REG_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state           <= ST_SETTLE;
      settleCount     <= '0;
      waitCount       <= '0;
      regDefaultsLoad <= 1'b1;
      polarity        <= 2'h0;
    end else begin
      state           <= next_state;
      // Pulses with the first cycle of registerMode; a power-down return
      // to the hold state keeps the host's settings
      regDefaultsLoad <= (state == ST_REG_HOLD) && !registerMode;
      if (state == ST_SETTLE && !settleDone) begin
        settleCount <= settleCount + 2'h1;
      end
      if (state == ST_WAIT && !waitDone) begin
        waitCount <= waitCount + 19'h0_0001;
      end
      if (state == ST_SETTLE && settleDone) begin
        polarity <= muteSync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration selection
  // ----------------------------------------------------------------
  wire pinMode = (state == ST_PIN_RUN);
  wire regMode = (state == ST_REG_HOLD) || (state == ST_REG_RUN);
  wire [1:0] pinSpeed = strapSync[3] ? (strapSync[2] ? 2'h2 : 2'h1)
                                     : 2'h0;
  wire [1:0] pinDeemph = (strapSync[3:2] == 2'h1) ? DEEMPH_441
                                                   : DEEMPH_NONE;
  wire [2:0] pinFormat = {1'b0, strapSync[1:0]};
  wire [1:0] selSpeed = regMode ? speedModeField : pinSpeed;
  wire [2:0] selFormat = regMode ? formatField : pinFormat;
  wire [1:0] selDeemph = regMode ? deemphField : pinDeemph;
  wire selSlow = regMode & filterSelect;
  wire selDiv = regMode & (masterClockDivideByTwo |
                           masterClockDivideByThree);
  wire [7:0] selOsr = (selSpeed == 2'h0) ? OSR_SINGLE :
                      (selSpeed == 2'h1) ? OSR_DOUBLE :
                                           OSR_QUAD;

  // ----------------------------------------------------------------
  // Clock-ratio check
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] ratioMeas;
  logic               ratioOkMeas;

  dmc_ratio_meter #(
    .W          (RATIO_W)
  ) u_meter (
    .clk        (clk),
    .resetn     (resetn),
    .frameEdge  (frameEdge),
    .speed      (selSpeed),
    .divEnable  (selDiv),
    .ratio      (ratioMeas),
    .ratioValid (ratioOkMeas)
  );

  // ----------------------------------------------------------------
  // Soft ramp and mute
  // ----------------------------------------------------------------
  logic [1:0] lastSpeed;
  wire active = pinMode || (state == ST_REG_RUN);
  wire modeChange = (selSpeed != lastSpeed);
  // A new frame length is a clock mode change as well
  wire ratioChange = (ratioMeas != clockRatio);
  wire restart = !active || modeChange || ratioChange;
  // Register mode uses the host volume; pin mode has none
  wire [VOL_W-1:0] target = regMode ? volumeField : VOL_ZERO;
  wire stepDown = frameEdge && (attenuation > target);
  wire stepUp = frameEdge && (attenuation < target);
  wire [VOL_W-1:0] next_attenuation = restart  ? VOL_MUTE :
                                      stepDown ? attenuation - 11'h001 :
                                      stepUp   ? attenuation + 11'h001 :
                                                 attenuation;
  wire autoMute = pinMode ? zeroData : 1'b0;
  wire muteNow = !active || autoMute || !ratioOkMeas;
  wire [1:0] effPol = (regMode && mutePolarityOverride[1])
                      ? {2{mutePolarityOverride[0]}} : polarity;
  // Pins float during settle so the bias can be sampled
  wire [1:0] next_muteOe = (state == ST_SETTLE) ? 2'h0 : 2'h3;
  wire [1:0] next_muteOut;

  // ----------------------------------------------------------------
  // Per-channel mute drive
  // ----------------------------------------------------------------
  // Muted drives effPol (the sampled bias level or the register override), playing drives its inverse
  for (genvar ch = 0; ch < 2; ch++) begin : g_mute
    assign next_muteOut[ch] = muteNow ? effPol[ch] : ~effPol[ch];
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speedMode          <= 2'h0;
      oversampleRatio    <= OSR_SINGLE;
      audioFormat        <= FMT_LJ24;
      deemphasis         <= DEEMPH_NONE;
      slowFilter         <= 1'b0;
      masterClockDivider <= 1'b0;
      lastSpeed          <= 2'h0;
    end else begin
      speedMode          <= selSpeed;
      oversampleRatio    <= selOsr;
      audioFormat        <= selFormat;
      deemphasis         <= selDeemph;
      slowFilter         <= selSlow;
      masterClockDivider <= selDiv;
      lastSpeed          <= selSpeed;
    end
  end

  // ----------------------------------------------------------------
  // Status, ramp and mute outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      registerMode <= 1'b0;
      running      <= 1'b0;
      clockRatio   <= '0;
      ratioValid   <= 1'b0;
    end else begin
      registerMode <= regMode;
      running      <= active;
      clockRatio   <= ratioMeas;
      ratioValid   <= ratioOkMeas;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      attenuation <= VOL_MUTE;
    end else begin
      attenuation <= next_attenuation;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      muteControlOutput <= 2'h0;
      muteControlOe     <= 2'h0;
    end else begin
      muteControlOutput <= next_muteOut;
      muteControlOe     <= next_muteOe;
    end
  end

endmodule : dmc_startup_ctrl

// ==== core/dmc_pkg.sv ====
/*
  Shared constants and types for the mode, clock-ratio and start-up control.
  Assumes a single 50 MHz system clock that also measures frame periods.
*/
package dmc_pkg;

  // ----------------------------------------------------------------
  // Speed modes and formats
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_SINGLE,
    SPD_DOUBLE,
    SPD_QUAD,
    SPD_RSVD
  } dmc_speed_t;

  localparam logic [2:0] FMT_LJ24 = 3'h0;
  localparam logic [2:0] FMT_I2S24 = 3'h1;
  localparam logic [2:0] FMT_RJ16 = 3'h2;
  localparam logic [2:0] FMT_RJ24 = 3'h3;

  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_441 = 2'h1;

  // Oversampling ratios per speed mode
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DOUBLE = 8'h40;
  localparam logic [7:0] OSR_QUAD = 8'h20;

  // Upper sample-rate limits in Hz
  localparam int RATE_SINGLE_HZ = 50000;
  localparam int RATE_DOUBLE_HZ = 100000;
  localparam int RATE_QUAD_HZ = 200000;

  // ----------------------------------------------------------------
  // Start-up timing and reset values
  // ----------------------------------------------------------------
  localparam int STARTUP_CYCLES = 262144;
  // Last settle edge count; mute pins need two edges to cross the sync
  localparam logic [1:0] SETTLE_LAST = 2'h2;
  localparam int RATIO_W = 12;
  localparam int VOL_W = 11;
  // Attenuation in eighth-dB steps at full mute
  localparam logic [10:0] VOL_MUTE = 11'h7FF;
  localparam logic [10:0] VOL_ZERO = 11'h000;
  localparam logic [1:0] MUTEP_AUTO = 2'h0;
  localparam logic [1:0] MUTEP_LOW = 2'h2;
  localparam logic [1:0] MUTEP_HIGH = 2'h3;

endpackage : dmc_pkg

// ==== core/dmc_ratio_meter.sv ====
/*
  Counts system clocks per frame-clock period and judges the ratio.
  Assumes the frame clock edge input is a clean one-cycle pulse.
*/
module dmc_ratio_meter
  import dmc_pkg::*;
#(
  parameter int W = dmc_pkg::RATIO_W
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             frameEdge,
  input  wire logic [1:0]       speed,
  input  wire logic             divEnable,
  output logic      [W-1:0]     ratio,
  output logic                  ratioValid
);

  logic [W-1:0] count;
  logic         ok;

  function automatic logic ratioOk(input logic [W-1:0] r,
                                   input logic [1:0] s,
                                   input logic d);
    case (s)
      2'h0: ratioOk = (r == W'(256)) || (r == W'(384)) || (r == W'(512))
        || (d && ((r == W'(768)) || (r == W'(1024)) || (r == W'(1152))));
      2'h1: ratioOk = (r == W'(128)) || (r == W'(192)) || (r == W'(256))
        || (r == W'(384)) || (d && (r == W'(512)));
      2'h2: ratioOk = (r == W'(96)) || (r == W'(128)) || (r == W'(192))
        || (d && ((r == W'(64)) || (r == W'(256))));
      default: ratioOk = 1'b0;
    endcase
  endfunction : ratioOk

  assign ok = ratioOk(count + W'(1), speed, divEnable);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count      <= '0;
      ratio      <= '0;
      ratioValid <= 1'b0;
    end else if (frameEdge) begin
      // Any phase between clocks is tolerated: only period length matters
      count      <= '0;
      ratio      <= count + W'(1);
      ratioValid <= ok;
    end else if (count != '1) begin
      count <= count + W'(1);
    end
  end

endmodule : dmc_ratio_meter

// ==== tb/dmc_startup_ctrl_props.sv ====
/*
  Port checker for the start-up control, bound to the top module.
  Assumes the top is reset by resetn and clocked by clk alone.
*/
module dmc_startup_ctrl_props
  import dmc_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       portEnableBit,
  input wire logic       powerDownBit,
  input wire logic       registerMode,
  input wire logic       running,
  input wire logic       regDefaultsLoad,
  input wire logic [1:0] speedMode,
  input wire logic [7:0] oversampleRatio,
  input wire logic       slowFilter,
  input wire logic       masterClockDivider
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Cycles since reset release, saturating
  // ----------------------------------------------------------------
  logic [19:0] upCount;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) upCount <= 20'h0_0000;
    else if (!(&upCount)) upCount <= upCount + 20'h0_0001;
  end
  single_osr_a: assert property ((speedMode == SPD_SINGLE) [*2]
    |-> oversampleRatio == OSR_SINGLE) else $error("bad single ratio");
  double_osr_a: assert property ((speedMode == SPD_DOUBLE) [*2]
    |-> oversampleRatio == OSR_DOUBLE) else $error("bad double ratio");
  quad_osr_a: assert property ((speedMode == SPD_QUAD) [*2]
    |-> oversampleRatio == OSR_QUAD) else $error("bad quad ratio");
  pin_fast_a: assert property (!registerMode |-> !slowFilter)
    else $error("slow filter in pin mode");
  pin_nodiv_a: assert property (!registerMode |-> !masterClockDivider)
    else $error("divider in pin mode");
  enable_defaults_a: assert property ($rose(registerMode)
    |-> regDefaultsLoad) else $error("no defaults on takeover");
  // Late enough to be a timeout, early enough to be the same one
  pin_start_a: assert property ($rose(running) && !registerMode
    |-> upCount >= STARTUP - 1 && upCount <= STARTUP + 8)
    else $error("pin start at wrong time");
  enable_takeover_a: assert property (portEnableBit && !registerMode
    |-> ##[1:3] registerMode) else $error("enable not taken");
  hold_down_a: assert property (registerMode && powerDownBit
    && !running |=> !running) else $error("ran while powered down");
  power_up_a: assert property (registerMode && !powerDownBit
    |-> ##[0:2] running) else $error("no power-up");
  cover property ($rose(running) && !registerMode);
  cover property ($rose(registerMode));
  cover property (registerMode && $fell(powerDownBit));
endmodule : dmc_startup_ctrl_props

bind dmc_startup_ctrl dmc_startup_ctrl_props #(.STARTUP(STARTUP)) props (
  .clk(clk), .resetn(resetn), .portEnableBit(portEnableBit),
  .powerDownBit(powerDownBit), .registerMode(registerMode),
  .running(running), .regDefaultsLoad(regDefaultsLoad),
  .speedMode(speedMode), .oversampleRatio(oversampleRatio),
  .slowFilter(slowFilter), .masterClockDivider(masterClockDivider)
);

// ==== tb/dmc_audio_src.sv ====
/*
  Audio source model: frame clock and a static-zero data flag.
  Assumes clk is the master clock; period counts clk cycles.
*/
module dmc_audio_src (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [11:0] period,
  output logic             frameClock,
  output logic             dataZero
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] phase = 12'h000;
  always @(posedge clk) begin
    if (!run || phase >= period - 12'h001) phase <= 12'h000;
    else phase <= phase + 12'h001;
  end
  // Skewed off the clock edge, and stands low outside frames
  assign #3 frameClock = run && (phase < (period >> 1));
  // Data held at static zero for the whole run
  assign dataZero = 1'b1;
endmodule : dmc_audio_src

// ==== tb/dmc_startup_ctrl_tb.sv ====
/*
  Self-checking bench for the start-up control: pin and register modes.
  Assumes the checker is bound from its own file.
*/
module dmc_startup_ctrl_tb
  import dmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SU = 64;
  logic clk = 1'b0, resetn = 1'b0, srcRun = 1'b1, frameClock, zeroData;
  logic [11:0] period = 12'h100;
  logic [3:0] strapPins = 4'h0;
  logic [1:0] muteSense = 2'h1, speedModeField = 2'h0, mutePolOvr = 2'h0;
  logic [2:0] formatField = 3'h0;
  logic portEnableBit = 1'b0, powerDownBit = 1'b1, filterSelect = 1'b0;
  logic div2 = 1'b0, registerMode, running, regDefaultsLoad, slowFilter;
  logic masterClockDivider, ratioValid;
  logic [1:0] speedMode, deemphasis, muteOut, muteOe;
  logic [7:0] oversampleRatio;
  logic [2:0] audioFormat;
  logic [VOL_W-1:0] attenuation;
  logic [RATIO_W-1:0] clockRatio;
  int err_total = 0, total_checks = 0;

  dmc_audio_src src (.clk(clk), .run(srcRun), .period(period),
    .frameClock(frameClock), .dataZero(zeroData));
  dmc_startup_ctrl #(.STARTUP(SU)) uut (.clk(clk), .resetn(resetn),
    .frameClock(frameClock), .strapPins(strapPins), .muteSense(muteSense),
    .portEnableBit(portEnableBit), .powerDownBit(powerDownBit),
    .speedModeField(speedModeField), .formatField(formatField),
    .deemphField(2'h0), .mutePolarityOverride(mutePolOvr),
    .filterSelect(filterSelect), .masterClockDivideByTwo(div2),
    .masterClockDivideByThree(1'b0), .volumeField(11'h000),
    .zeroData(zeroData), .registerMode(registerMode), .running(running),
    .regDefaultsLoad(regDefaultsLoad), .speedMode(speedMode),
    .oversampleRatio(oversampleRatio), .audioFormat(audioFormat),
    .deemphasis(deemphasis), .slowFilter(slowFilter),
    .masterClockDivider(masterClockDivider), .attenuation(attenuation),
    .clockRatio(clockRatio), .ratioValid(ratioValid),
    .muteControlOutput(muteOut), .muteControlOe(muteOe));

  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Samples land away from the edge that updates them
  task automatic settle;
    @(negedge clk);
  endtask : settle
  task automatic do_reset;
    resetn <= 1'b0;
    cyc(6);
    resetn <= 1'b1;
  endtask : do_reset
  task automatic wait_run(output int n);
    n = 0;
    while (running !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      close_out();
    end
  endtask : wait_run
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_pin;
    int n;
    logic [VOL_W-1:0] a0;
    strapPins <= 4'b1010;
    filterSelect <= 1'b1;
    div2 <= 1'b1;
    do_reset();
    wait_run(n);
    settle();
    check(16'(n >= SU && n <= SU + 8), 16'h1);
    check(registerMode, 1'b0);
    check(speedMode, SPD_DOUBLE);
    check(oversampleRatio, OSR_DOUBLE);
    check(audioFormat, FMT_RJ16);
    check(slowFilter, 1'b0);
    check(masterClockDivider, 1'b0);
    check(muteOut, 2'h1);
    check(muteOe, 2'h3);
    check(deemphasis, DEEMPH_NONE);
    cyc(1024);
    settle();
    check(ratioValid, 1'b1);
    check(clockRatio, 12'h100);
    a0 = attenuation;
    cyc(256);
    settle();
    check(16'(a0 - attenuation), 16'h1);
    $display("pin mode test done");
  endtask : test_pin
  task automatic test_reg;
    int n;
    cyc(1);
    strapPins <= 4'h0;
    speedModeField <= 2'h2;
    formatField <= 3'h4;
    mutePolOvr <= 2'h3;
    div2 <= 1'b0;
    period <= 12'h080;
    do_reset();
    cyc(4);
    portEnableBit <= 1'b1;
    cyc(SU + 16);
    settle();
    check(registerMode, 1'b1);
    check(running, 1'b0);
    cyc(1);
    powerDownBit <= 1'b0;
    wait_run(n);
    cyc(1024);
    settle();
    check(speedMode, SPD_QUAD);
    check(oversampleRatio, OSR_QUAD);
    check(audioFormat, 3'h4);
    check(slowFilter, 1'b1);
    // Override makes the muted level high; playing drives the inverse
    check(muteOut, 2'h0);
    check(ratioValid, 1'b1);
    cyc(1);
    period <= 12'h040;
    cyc(1024);
    settle();
    check(ratioValid, 1'b0);
    cyc(1);
    div2 <= 1'b1;
    cyc(1024);
    settle();
    check(ratioValid, 1'b1);
    cyc(1);
    div2 <= 1'b0;
    speedModeField <= 2'h0;
    period <= 12'h180;
    cyc(1024);
    settle();
    check(oversampleRatio, OSR_SINGLE);
    check(ratioValid, 1'b1);
    $display("register mode test done");
  endtask : test_reg

  initial begin
    test_pin();
    test_reg();
    close_out();
  end
endmodule : dmc_startup_ctrl_tb
